// ===== src/psr_cfg.svh
// Purpose: shared constants of the async psram bus ends
// Assumes: one 10 MHz clock on both ends
// Notes:   definitions only
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// ************************************
// widths
// ************************************
`define PSR_ADDR_W      21
`define PSR_DATA_W      16
`define PSR_CNT_W       12
`define PSR_MEM_DEPTH   (1 << `PSR_ADDR_W)
// ************************************
// byte lanes of the data word
// ************************************
`define PSR_LO_LSB      0
`define PSR_LO_MSB      7
`define PSR_HI_LSB      8
`define PSR_HI_MSB      15
// ************************************
// mode register
// ************************************
`define PSR_MODE_LO     14
`define PSR_MODE_HI     15
`define PSR_MODE_ASYNC  2'h0
`define PSR_MODE_RST    21'h000000
`define PSR_MODE_WORD   21'h000000
// ************************************
// timing
// ************************************
`define PSR_CLK_MHZ     10
`define PSR_POWERUP_US  200
`define PSR_POWERUP_CYC (`PSR_POWERUP_US * `PSR_CLK_MHZ)
`define PSR_STROBE_CYC  2
`endif

// ===== src/psr_pkg.sv
// Purpose: types shared by both bus ends
// Assumes: constants come from psr_cfg.svh
// Notes:   no numbers here
package psr_pkg;
   // device power-up tracking
   typedef enum logic [1:0] {PSR_PU_WAIT, PSR_PU_READY, PSR_PU_STABLE} psr_pwr_e;
   // host sequencer
   typedef enum logic [2:0] {
      PSR_H_POWER, PSR_H_IDLE, PSR_H_SETUP, PSR_H_STROBE, PSR_H_HOLD
   } psr_host_e;
   // kind of bus cycle the host runs
   typedef enum logic [1:0] {PSR_K_READ, PSR_K_WRITE, PSR_K_MODE} psr_kind_e;
endpackage : psr_pkg

// ===== src/psr_bus_if.sv
// Purpose: pins between memory controller and psram
// Assumes: each end drives its own copy plus enables
// Notes:   wire levels resolved here, per byte lane
`timescale 1ns/1ns
`include "psr_cfg.svh"
interface psr_bus_if;
   // control pins, all driven by the host
   logic                   csN;
   logic                   oeN;
   logic                   weN;
   logic                   lowerByteLaneN;
   logic                   upperByteLaneN;
   logic                   addressValidN;
   logic                   powerSaveN;
   logic                   clkPin;
   logic [`PSR_ADDR_W-1:0] addr;
   // data lanes, one copy per driver
   logic [`PSR_DATA_W-1:0] dqHost;
   logic [1:0]             dqHostOe;
   logic [`PSR_DATA_W-1:0] dqDev;
   logic [1:0]             dqDevOe;
   wire  [`PSR_DATA_W-1:0] dq;
   // wait pin from the device
   logic                   waitOut;
   logic                   waitOe;
   wire                    waitLine;

   // lane resolution, device wins a clash so it shows up as a wrong value;
   // a lane nobody drives reads as zero, the released level of this model
   assign dq[`PSR_LO_MSB:`PSR_LO_LSB] = dqDevOe[0] ? dqDev[`PSR_LO_MSB:`PSR_LO_LSB]
      : (dqHostOe[0] ? dqHost[`PSR_LO_MSB:`PSR_LO_LSB] : 8'h00);
   assign dq[`PSR_HI_MSB:`PSR_HI_LSB] = dqDevOe[1] ? dqDev[`PSR_HI_MSB:`PSR_HI_LSB]
      : (dqHostOe[1] ? dqHost[`PSR_HI_MSB:`PSR_HI_LSB] : 8'h00);
   // released wait pin reads low
   assign waitLine = waitOe & waitOut;

   modport device (
      input  csN, oeN, weN, lowerByteLaneN, upperByteLaneN, addressValidN,
      input  powerSaveN, addr, dq,
      output dqDev, dqDevOe, waitOut, waitOe
   );
   modport host (
      output csN, oeN, weN, lowerByteLaneN, upperByteLaneN, addressValidN,
      output powerSaveN, clkPin, addr, dqHost, dqHostOe,
      input  dq
   );
endinterface : psr_bus_if

// ===== src/psr_device_end.sv
// Purpose: psram device end, async page read / async write bus mode
// Assumes: pins synchronous to clock; host keeps don't-care pins at valid levels
// Notes:   lane direction is decoded live from the pins, not registered
`timescale 1ns/1ns
`include "psr_cfg.svh"
module psr_device_end
   import psr_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             srst,
   // pins toward the controller
   psr_bus_if.device             bus,
   // status toward local logic
   output logic [1:0]            modeField,
   output logic                  asyncMode,
   output logic                  powerUpDone,
   output logic                  standbyStable
);

   // ************************************
   // storage
   // ************************************
   // whole array kept, no refresh model
   logic [`PSR_DATA_W-1:0] mem [0:`PSR_MEM_DEPTH-1];

   // mode word and power tracking state
   logic [`PSR_ADDR_W-1:0] modeWord_reg;
   logic [`PSR_ADDR_W-1:0] modeWord_next;
   logic                   async_reg;
   logic                   async_next;
   psr_pwr_e               pwr_reg;
   psr_pwr_e               pwr_next;
   logic [`PSR_CNT_W-1:0]  cnt_reg;
   logic [`PSR_CNT_W-1:0]  cnt_next;
   // status flags, registered so the status pins come from flops
   logic                   done_reg;
   logic                   done_next;
   logic                   stable_reg;
   logic                   stable_next;

   // ************************************
   // live decode
   // ************************************
   // decode terms, all combinational from the pins and the mode word
   logic selected;
   logic readCyc;
   logic writeCyc;
   logic rdLo;
   logic rdHi;
   logic wrLo;
   logic wrHi;
   logic modeLoad;
   logic anyAccess;
   logic liveAsync;

   // used by the live decode and by the status copy
   function automatic logic isAsync(input logic [`PSR_ADDR_W-1:0] w);
      isAsync = (w[`PSR_MODE_HI:`PSR_MODE_LO] == `PSR_MODE_ASYNC);
   endfunction : isAsync

   // pin decode, no flops so direction follows the pins at once; an unknown
   // on a don't-care pin would spread into the lane enables, so the host
   // must hold every control pin at a level
   always_comb begin
      liveAsync = isAsync(modeWord_reg);
      selected  = ~bus.csN;
      modeLoad  = selected & ~bus.addressValidN & ~bus.weN & bus.oeN
                & ~bus.lowerByteLaneN & ~bus.upperByteLaneN;
      // clock not used here; address-valid only enters the mode load term
      readCyc   = selected & liveAsync & ~bus.oeN & bus.weN;
      writeCyc  = selected & liveAsync & bus.oeN & ~bus.weN & ~modeLoad;
      // both lanes high or oe/we high: nothing
      rdLo      = readCyc & ~bus.lowerByteLaneN;
      rdHi      = readCyc & ~bus.upperByteLaneN;
      wrLo      = writeCyc & ~bus.lowerByteLaneN;
      wrHi      = writeCyc & ~bus.upperByteLaneN;
      anyAccess = rdLo | rdHi | wrLo | wrHi | modeLoad;
   end

   // ************************************
   // pin drive
   // ************************************
   // limits of this model: no refresh, page buffer or deep power down;
   // words never written read back as unknown; a mode word other than
   // async blocks all array access until a new mode load
   // trade: the live decode costs a wide mux but needs no turnaround cycle
   // read data straight from the array; a clash with the host is its fault
   always_comb begin
      bus.dqDev   = mem[bus.addr];
      bus.dqDevOe = {rdHi, rdLo};
      bus.waitOut = 1'b0;
      bus.waitOe  = 1'b0;
   end

   // array write on each edge the write decode holds; a write held for
   // several edges stores the same lanes again, which is harmless
   always_ff @(posedge clock) begin
      if (wrLo) begin
         mem[bus.addr][`PSR_LO_MSB:`PSR_LO_LSB] <= bus.dq[`PSR_LO_MSB:`PSR_LO_LSB];
      end
      if (wrHi) begin
         mem[bus.addr][`PSR_HI_MSB:`PSR_HI_LSB] <= bus.dq[`PSR_HI_MSB:`PSR_HI_LSB];
      end
   end

   // ************************************
   // mode register and power-up
   // ************************************
   // power tracker: counts edges with select and save high, then waits for
   // the first real access; accesses during the wait are still served, the
   // tracker only reports status
   // a mode load never reaches the array, the write decode excludes it
   // next state of mode word and power tracking
   always_comb begin
      modeWord_next = modeWord_reg;
      pwr_next      = pwr_reg;
      cnt_next      = cnt_reg;
      // load whole address into mode word
      if (modeLoad) begin
         modeWord_next = bus.addr;
      end
      async_next = isAsync(modeWord_next);
      unique case (pwr_reg)
         PSR_PU_WAIT: begin
            // count only while select and save high
            if (bus.csN & bus.powerSaveN) begin
               if (cnt_reg == `PSR_CNT_W'(`PSR_POWERUP_CYC - 1)) begin
                  pwr_next = PSR_PU_READY;
               end else begin
                  cnt_next = cnt_reg + `PSR_CNT_W'(1);
               end
            end else begin
               cnt_next = '0;
            end
         end
         PSR_PU_READY: begin
            if (anyAccess) begin
               pwr_next = PSR_PU_STABLE;
            end
         end
         PSR_PU_STABLE: begin
            pwr_next = PSR_PU_STABLE;
         end
      endcase
      // flags from the next power state keep the status pins registered
      done_next   = (pwr_next != PSR_PU_WAIT);
      stable_next = (pwr_next == PSR_PU_STABLE);
   end

   // registers only; reset to async default
   always_ff @(posedge clock) begin
      if (srst) begin
         modeWord_reg <= `PSR_MODE_RST;
         async_reg    <= 1'b1;
         pwr_reg      <= PSR_PU_WAIT;
         cnt_reg      <= '0;
         done_reg     <= 1'b0;
         stable_reg   <= 1'b0;
      end else begin
         modeWord_reg <= modeWord_next;
         async_reg    <= async_next;
         pwr_reg      <= pwr_next;
         cnt_reg      <= cnt_next;
         done_reg     <= done_next;
         stable_reg   <= stable_next;
      end
   end

   // ************************************
   // status
   // ************************************
   // status straight from flops
   assign modeField     = modeWord_reg[`PSR_MODE_HI:`PSR_MODE_LO];
   assign asyncMode     = async_reg;
   assign powerUpDone   = done_reg;
   assign standbyStable = stable_reg;

endmodule : psr_device_end

// ===== src/psr_host_end.sv
// Purpose: memory controller end of the async psram bus
// Assumes: one request at a time from local logic
// Notes:   runs power-up wait, mode load, dummy read, then serves requests
`timescale 1ns/1ns
`include "psr_cfg.svh"
module psr_host_end
   import psr_pkg::*;
(
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   srst,
   // pins toward the device
   psr_bus_if.host                     bus,
   // request from local logic
   input  wire logic                   reqValid,
   input  wire logic                   reqWrite,
   input  wire logic [`PSR_ADDR_W-1:0] reqAddr,
   input  wire logic [`PSR_DATA_W-1:0] reqData,
   input  wire logic [1:0]             reqLanes,
   // answer to local logic
   output logic                        reqReady,
   output logic                        respValid,
   output logic [`PSR_DATA_W-1:0]      respData,
   output logic                        initDone
);

   // ************************************
   // state
   // ************************************
   psr_host_e              st_reg, st_next;
   psr_kind_e              kind_reg, kind_next;
   logic [`PSR_CNT_W-1:0]  cnt_reg, cnt_next;
   logic                   init_reg, init_next;
   logic                   csN_reg, csN_next;
   logic                   oeN_reg, oeN_next;
   logic                   weN_reg, weN_next;
   logic                   advN_reg, advN_next;
   logic [1:0]             lanesN_reg, lanesN_next;
   logic [`PSR_ADDR_W-1:0] addr_reg, addr_next;
   logic [`PSR_DATA_W-1:0] wdat_reg, wdat_next;
   logic [1:0]             dqOe_reg, dqOe_next;
   logic [`PSR_DATA_W-1:0] rdat_reg, rdat_next;
   logic                   resp_reg, resp_next;
   logic                   ready_reg, ready_next;

   // sequencer; unused pins parked at valid levels
   always_comb begin
      st_next     = st_reg;
      kind_next   = kind_reg;
      cnt_next    = cnt_reg;
      init_next   = init_reg;
      csN_next    = csN_reg;
      oeN_next    = oeN_reg;
      weN_next    = weN_reg;
      advN_next   = advN_reg;
      lanesN_next = lanesN_reg;
      addr_next   = addr_reg;
      wdat_next   = wdat_reg;
      dqOe_next   = dqOe_reg;
      rdat_next   = rdat_reg;
      resp_next   = 1'b0;
      ready_next  = 1'b0;
      unique case (st_reg)
         PSR_H_POWER: begin
            // select and save high for the wait
            if (cnt_reg == `PSR_CNT_W'(`PSR_POWERUP_CYC - 1)) begin
               st_next   = PSR_H_SETUP;
               kind_next = PSR_K_MODE;
               addr_next = `PSR_MODE_WORD;
               csN_next  = 1'b0;
               cnt_next  = '0;
            end else begin
               cnt_next = cnt_reg + `PSR_CNT_W'(1);
            end
         end
         PSR_H_IDLE: begin
            ready_next = 1'b1;
            if (reqValid & reqReady) begin
               st_next     = PSR_H_SETUP;
               kind_next   = reqWrite ? PSR_K_WRITE : PSR_K_READ;
               addr_next   = reqAddr;
               wdat_next   = reqData;
               lanesN_next = ~reqLanes;
               csN_next    = 1'b0;
               ready_next  = 1'b0;
            end
         end
         PSR_H_SETUP: begin
            st_next  = PSR_H_STROBE;
            cnt_next = '0;
            unique case (kind_reg)
               PSR_K_READ: oeN_next = 1'b0;
               PSR_K_WRITE: begin
                  weN_next  = 1'b0;
                  dqOe_next = ~lanesN_reg;
               end
               PSR_K_MODE: begin
                  weN_next    = 1'b0;
                  advN_next   = 1'b0;
                  lanesN_next = 2'h0;
               end
            endcase
         end
         PSR_H_STROBE: begin
            if (cnt_reg == `PSR_CNT_W'(`PSR_STROBE_CYC - 1)) begin
               st_next     = PSR_H_HOLD;
               rdat_next   = bus.dq;
               csN_next    = 1'b1;
               oeN_next    = 1'b1;
               weN_next    = 1'b1;
               advN_next   = 1'b1;
               dqOe_next   = 2'h0;
            end else begin
               cnt_next = cnt_reg + `PSR_CNT_W'(1);
            end
         end
         PSR_H_HOLD: begin
            st_next = PSR_H_IDLE;
            if (kind_reg == PSR_K_MODE) begin
               // dummy word read after the mode load
               st_next     = PSR_H_SETUP;
               kind_next   = PSR_K_READ;
               lanesN_next = 2'h0;
               csN_next    = 1'b0;
            end else if (!init_reg) begin
               init_next  = 1'b1;
               ready_next = 1'b1;
            end else begin
               resp_next  = 1'b1;
               ready_next = 1'b1;
            end
         end
      endcase
   end

   // registers only; select, strobe and lane pins idle high out of reset
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg     <= PSR_H_POWER;
         kind_reg   <= PSR_K_READ;
         cnt_reg    <= '0;
         init_reg   <= 1'b0;
         csN_reg    <= 1'b1;
         oeN_reg    <= 1'b1;
         weN_reg    <= 1'b1;
         advN_reg   <= 1'b1;
         lanesN_reg <= 2'h3;
         addr_reg   <= '0;
         wdat_reg   <= '0;
         dqOe_reg   <= 2'h0;
         rdat_reg   <= '0;
         resp_reg   <= 1'b0;
         ready_reg  <= 1'b0;
      end else begin
         st_reg     <= st_next;
         kind_reg   <= kind_next;
         cnt_reg    <= cnt_next;
         init_reg   <= init_next;
         csN_reg    <= csN_next;
         oeN_reg    <= oeN_next;
         weN_reg    <= weN_next;
         advN_reg   <= advN_next;
         lanesN_reg <= lanesN_next;
         addr_reg   <= addr_next;
         wdat_reg   <= wdat_next;
         dqOe_reg   <= dqOe_next;
         rdat_reg   <= rdat_next;
         resp_reg   <= resp_next;
         ready_reg  <= ready_next;
      end
   end

   // pins and answers straight from flops; save pin tied high, clock pin parked low
   assign bus.csN            = csN_reg;
   assign bus.oeN            = oeN_reg;
   assign bus.weN            = weN_reg;
   assign bus.addressValidN  = advN_reg;
   assign bus.lowerByteLaneN = lanesN_reg[0];
   assign bus.upperByteLaneN = lanesN_reg[1];
   assign bus.powerSaveN     = 1'b1;
   assign bus.clkPin         = 1'b0;
   assign bus.addr           = addr_reg;
   assign bus.dqHost         = wdat_reg;
   assign bus.dqHostOe       = dqOe_reg;
   assign reqReady           = ready_reg;
   assign respValid          = resp_reg;
   assign respData           = rdat_reg;
   assign initDone           = init_reg;

endmodule : psr_host_end

// ===== tb/psr_bus_checker.sv
// Purpose: pin checks on the async psram bus
// Assumes: one clock, mode word stays async
// Notes:   sees the interface signals only
`timescale 1ns/1ns
`include "psr_cfg.svh"
module psr_bus_checker (
   // clock and reset
   input wire logic       clock,
   input wire logic       srst,
   // host pins
   input wire logic       csN,
   input wire logic       oeN,
   input wire logic       weN,
   input wire logic       lowerByteLaneN,
   input wire logic       upperByteLaneN,
   input wire logic       addressValidN,
   input wire logic       powerSaveN,
   // device drive
   input wire logic [1:0] dqDevOe,
   input wire logic       waitOe
);
   localparam int puLast = `PSR_POWERUP_CYC - 1;
   logic [`PSR_CNT_W-1:0] puCnt_reg;
   logic [`PSR_CNT_W-1:0] puCnt_next;
   logic                  selRd;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   // cycles since reset release, saturates so it never wraps
   always_comb begin
      puCnt_next = puCnt_reg;
      if (puCnt_reg < `PSR_POWERUP_CYC) begin
         puCnt_next = puCnt_reg + 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         puCnt_reg <= '0;
      end else begin
         puCnt_reg <= puCnt_next;
      end
   end
   assign selRd = !csN && !oeN && weN;

   deselect_float_a: assert property (csN |-> dqDevOe == 2'h0)
      else $error("device drives while deselected");
   idle_float_a: assert property (!csN && oeN && weN |-> dqDevOe == 2'h0)
      else $error("device drives with output disabled");
   lanes_off_a: assert property (!csN && lowerByteLaneN && upperByteLaneN |-> !dqDevOe)
      else $error("device drives with no lane selected");
   low_read_a: assert property (selRd && !lowerByteLaneN && upperByteLaneN |-> dqDevOe == 2'h1)
      else $error("lower byte read lanes wrong");
   high_read_a: assert property (selRd && lowerByteLaneN && !upperByteLaneN |-> dqDevOe == 2'h2)
      else $error("upper byte read lanes wrong");
   word_read_a: assert property (selRd && !lowerByteLaneN && !upperByteLaneN |-> dqDevOe == 2'h3)
      else $error("word read lanes wrong");
   write_float_a: assert property (!csN && oeN && !weN |-> dqDevOe == 2'h0)
      else $error("device drives during write");
   wait_float_a: assert property (!waitOe)
      else $error("wait pin driven");
   powerup_hold_a: assert property (puCnt_reg < puLast |-> csN && powerSaveN)
      else $error("select or save low during power-up");
   mode_load_a: assert property ($fell(addressValidN) |->
      (!csN && !weN && oeN && !lowerByteLaneN && !upperByteLaneN)[*2] ##1 addressValidN)
      else $error("mode load strobe malformed");
endmodule : psr_bus_checker

// ===== tb/tb_psram_async_mode_bus.sv
// Purpose: both bus ends joined, driven from the host request port
// Assumes: device array unknown until written
// Notes:   power-up wait runs at full 2000 cycles
`timescale 1ns/1ns
`include "psr_cfg.svh"
module tb_psram_async_mode_bus;
   // ************************************
   // signals
   // ************************************
   logic                   clock;
   logic                   srst;
   logic                   reqValid;
   logic                   reqWrite;
   logic [`PSR_ADDR_W-1:0] reqAddr;
   logic [`PSR_DATA_W-1:0] reqData;
   logic [1:0]             reqLanes;
   logic                   reqReady;
   logic                   respValid;
   logic [`PSR_DATA_W-1:0] respData;
   logic                   initDone;
   logic [1:0]             modeField;
   logic                   asyncMode;
   logic                   powerUpDone;
   logic                   standbyStable;
   int                     miscompares;
   int                     compares;

   psr_bus_if bus ();
   psr_device_end i_psr_device_end (.clock(clock), .srst(srst), .bus(bus),
      .modeField(modeField), .asyncMode(asyncMode), .powerUpDone(powerUpDone),
      .standbyStable(standbyStable));
   psr_host_end i_psr_host_end (.clock(clock), .srst(srst), .bus(bus),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
      .reqLanes(reqLanes), .reqReady(reqReady), .respValid(respValid),
      .respData(respData), .initDone(initDone));
   psr_bus_checker i_psr_bus_checker (.clock(clock), .srst(srst), .csN(bus.csN),
      .oeN(bus.oeN), .weN(bus.weN), .lowerByteLaneN(bus.lowerByteLaneN),
      .upperByteLaneN(bus.upperByteLaneN), .addressValidN(bus.addressValidN),
      .powerSaveN(bus.powerSaveN), .dqDevOe(bus.dqDevOe), .waitOe(bus.waitOe));

   // ************************************
   // helpers
   // ************************************
   // 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic summarize;
      if (miscompares == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // a wait that runs out ends the run as a failure
   task automatic timed_out;
      miscompares++;
      summarize;
   endtask : timed_out

   // one request; held until the taking edge, answer within 20 cycles
   task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d,
                         input logic [1:0] ln);
      int n;
      n = 0;
      @(posedge clock);
      reqValid <= 1'h1;
      reqWrite <= wr;
      reqAddr  <= a;
      reqData  <= d;
      reqLanes <= ln;
      // ready is read before this edge's updates, so it is the level just taken
      do begin
         @(posedge clock);
         n++;
      end while (reqReady !== 1'h1 && n < 20);
      reqValid <= 1'h0;
      if (reqReady !== 1'h1) timed_out;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (respValid !== 1'h1 && n < 20);
      if (respValid !== 1'h1) timed_out;
   endtask : access

   // ************************************
   // scenarios
   // ************************************
   task automatic sc_init;
      int n;
      n = 0;
      while (bus.csN === 1'h1 && n < 3000) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (bus.csN === 1'h1) timed_out;
      chk((n >= `PSR_POWERUP_CYC) ? 16'h1 : 16'h0, 16'h1);
      n = 0;
      while (initDone !== 1'h1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (initDone !== 1'h1) timed_out;
      chk({14'h0, modeField}, {14'h0, `PSR_MODE_ASYNC});
      chk({13'h0, asyncMode, powerUpDone, standbyStable}, 16'h7);
      chk({12'h0, bus.dqDevOe, bus.dqHostOe}, 16'h0000);
      chk({14'h0, bus.waitOe, bus.waitLine}, 16'h0000);
   endtask : sc_init

   // byte-lane writes merge into one word, byte reads float the other lane
   task automatic sc_lanes;
      access(1'h1, 21'h0a5a5a, 16'h1234, 2'h3);
      access(1'h1, 21'h0a5a5a, 16'h77ab, 2'h1);
      access(1'h1, 21'h0a5a5a, 16'hcd55, 2'h2);
      access(1'h0, 21'h0a5a5a, 16'h0000, 2'h3);
      chk(respData, 16'hcdab);
      access(1'h0, 21'h0a5a5a, 16'h0000, 2'h1);
      chk(respData, 16'h00ab);
      access(1'h0, 21'h0a5a5a, 16'h0000, 2'h2);
      chk(respData, 16'hcd00);
   endtask : sc_lanes

   // top address, back-to-back writes, cycles with no lane selected
   task automatic sc_edges;
      access(1'h1, 21'h1fffff, 16'hbeef, 2'h3);
      access(1'h1, 21'h000001, 16'h0f0f, 2'h3);
      access(1'h1, 21'h1fffff, 16'hffff, 2'h0);
      access(1'h0, 21'h1fffff, 16'h0000, 2'h3);
      chk(respData, 16'hbeef);
      access(1'h0, 21'h1fffff, 16'h0000, 2'h0);
      chk(respData, 16'h0000);
      access(1'h0, 21'h000001, 16'h0000, 2'h3);
      chk(respData, 16'h0f0f);
      chk({12'h0, bus.dqDevOe, bus.dqHostOe}, 16'h0000);
   endtask : sc_edges

   // ************************************
   // main sequence
   // ************************************
   initial begin
      miscompares = 0;
      compares    = 0;
      srst        = 1'h1;
      reqValid    = 1'h0;
      reqWrite    = 1'h0;
      reqAddr     = 21'h000000;
      reqData     = 16'h0000;
      reqLanes    = 2'h0;
      repeat (16) @(posedge clock);
      srst <= 1'h0;
      sc_init;
      sc_lanes;
      sc_edges;
      summarize;
   end
endmodule : tb_psram_async_mode_bus
